//--- slp_defines.vh
/*
 * Offsets, field positions, reset values and fixed figures for the
 * link parameter register bank.
 * Assumes it is included by bare name from the bank's design files.
 */
`ifndef SLP_DEFINES_VH
`define SLP_DEFINES_VH

// Register offsets on the 12-bit register port
`define SLP_ADDR_W 12
`define SLP_OFS_LANES 12'h58b
`define SLP_OFS_OCTETS 12'h58c
`define SLP_OFS_FRAMES 12'h58d
`define SLP_OFS_CONVS 12'h58e
`define SLP_OFS_CSN 12'h58f
`define SLP_OFS_SUBCLASS_NP 12'h590
`define SLP_OFS_SAMPLES 12'h591
`define SLP_OFS_DENSITY_CTRL 12'h592
`define SLP_OFS_CHK0 12'h5a0

// Field positions
`define SLP_SCR_BIT 7
`define SLP_CS_HI 7
`define SLP_CS_LO 6
`define SLP_SUBCLASS_HI 7
`define SLP_SUBCLASS_LO 5
`define SLP_DENSITY_BIT 7

// Reset values
`define SLP_RST_LANES 5'h07
`define SLP_RST_SCR 1'h0
`define SLP_RST_OCTETS 8'h00
`define SLP_RST_FRAMES 5'h1f
`define SLP_RST_CONVS 8'h01
`define SLP_RST_CS 2'h0
`define SLP_RST_RES 5'h0f
`define SLP_RST_SUBCLASS 3'h1
`define SLP_RST_NP 5'h0f
`define SLP_RST_CHK0 8'hc3
`define SLP_SAMPLES_RSVD 3'h1

// Control bit selection code for all three control bits
`define SLP_CS_ALL 2'h3

// Lane 0 constant part of the checksum (identifiers, version, lane id);
// chosen so that the sum over the reset configuration gives the reset checksum
`define SLP_CHK0_BASE 8'h7d

`endif

//--- slp_checksum.v
/*
 * Lane configuration checksum: sum of the lane's link parameter fields
 * modulo 256, purely combinational.
 * Assumes the caller registers the result and supplies the lane constant.
 */
`include "slp_defines.vh"

module slp_checksum (
	// Lane constant part
	input wire [7:0] i_base,
	// Link parameter fields
	input wire [4:0] i_lanes,
	input wire i_scr,
	input wire [7:0] i_octets,
	input wire [4:0] i_frames,
	input wire [7:0] i_convs,
	input wire [1:0] i_cs,
	input wire [4:0] i_res,
	input wire [2:0] i_subclass,
	input wire [4:0] i_np,
	input wire [4:0] i_samples,
	input wire i_high_density,
	input wire [4:0] i_ctrl_words,
	// Result
	output wire [7:0] o_sum
);
	wire [7:0] lanes_w = {3'h0, i_lanes};
	wire [7:0] scr_w = {7'h00, i_scr};
	wire [7:0] frames_w = {3'h0, i_frames};
	wire [7:0] cs_w = {6'h00, i_cs};
	wire [7:0] res_w = {3'h0, i_res};
	wire [7:0] sub_w = {5'h00, i_subclass};
	wire [7:0] np_w = {3'h0, i_np};
	wire [7:0] smp_w = {3'h0, i_samples};
	wire [7:0] dens_w = {7'h00, i_high_density};
	wire [7:0] ctrlw_w = {3'h0, i_ctrl_words};

	// 8-bit sum wraps naturally, which is the modulo 256
	assign o_sum = i_base + lanes_w + scr_w + i_octets + frames_w + i_convs + cs_w + res_w + sub_w + np_w
		+ smp_w + dens_w + ctrlw_w;
endmodule // slp_checksum

//--- slp_regs.v
/*
 * Link parameter register bank for the transmit serial link: lanes,
 * octets per frame, frames per multiframe, converters, control bits and
 * resolution, subclass and bits per sample, the read-only descriptors and
 * the lane 0 checksum.
 * Assumes a register master on a plain strobe port, synchronous to
 * I_REF_CLK, and descriptor inputs set by the device's mode logic.
 */
// Overview of operation
// - A control-bits code of binary 11 attaches control bits 2, 1 and 0 to every sample.
// - Samples per converter per frame cycle is the read-only five-bit descriptor field plus one.
// - The top descriptor bit is a read-only high density flag, 1 for enabled and 0 for disabled.
// - Control words per frame per link is reported as the read-only five-bit field with no offset.
// - Each lane checksum is the sum of the lane's link parameters modulo 256.
// - The lane 0 checksum reads as a read-only eight-bit value with a reset value of 0xc3.
// - Octets per frame is the eight-bit field value plus one.
`include "slp_defines.vh"

module slp_regs (
	// Clock, reset, enable
	input wire I_REF_CLK,
	input wire I_SYS_RST,
	input wire i_clk_en,
	// Register port
	input wire [`SLP_ADDR_W-1:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output wire [7:0] o_rdata,
	// Descriptors from the mode logic
	input wire [4:0] i_samples_field,
	input wire i_high_density_flag,
	input wire [4:0] i_ctrl_words_per_frame,
	// Link configuration outputs
	output wire [2:0] o_ctrl_bit_mask,
	output wire [4:0] o_resolution,
	output wire [4:0] o_lanes_field,
	output wire o_scrambler_en,
	output wire [8:0] o_octets_per_frame,
	output wire [5:0] o_frames_per_multiframe,
	output wire [7:0] o_converters,
	output wire [2:0] o_subclass,
	output wire [4:0] o_bits_per_sample,
	output wire [5:0] o_samples_per_frame,
	output wire o_high_density,
	output wire [4:0] o_ctrl_words,
	output wire o_frame_size_legal,
	output wire [7:0] o_lane_zero_checksum
);
	reg [4:0] lanes_r;
	reg scr_r;
	reg [7:0] octets_r;
	reg [4:0] frames_r;
	reg [7:0] convs_r;
	reg [1:0] cs_r;
	reg [4:0] res_r;
	reg [2:0] subclass_r;
	reg [4:0] np_r;
	reg [4:0] samples_r;
	reg dens_r;
	reg [4:0] ctrl_words_r;
	reg [7:0] chk0_r;
	reg [7:0] rdata_r;
	reg [7:0] rdata_nxt;
	reg [2:0] mask_r;
	reg [2:0] mask_nxt;
	reg [8:0] octets_out_r;
	reg [5:0] frames_out_r;
	reg [5:0] samples_out_r;
	reg legal_r;
	wire [7:0] chk0_nxt;
	wire [13:0] fk_product;

	// Writable parameter registers; read-only offsets drop writes
	always @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			lanes_r <= `SLP_RST_LANES;
			scr_r <= `SLP_RST_SCR;
			octets_r <= `SLP_RST_OCTETS;
			frames_r <= `SLP_RST_FRAMES;
			convs_r <= `SLP_RST_CONVS;
			cs_r <= `SLP_RST_CS;
			res_r <= `SLP_RST_RES;
			subclass_r <= `SLP_RST_SUBCLASS;
			np_r <= `SLP_RST_NP;
		end else if (i_clk_en && i_wr) begin
			case (i_addr)
				`SLP_OFS_LANES: begin
					scr_r <= i_wdata[`SLP_SCR_BIT];
					lanes_r <= i_wdata[4:0];
				end
				`SLP_OFS_OCTETS: octets_r <= i_wdata;
				// Legality of F x K is left to software; only flagged below
				`SLP_OFS_FRAMES: frames_r <= i_wdata[4:0];
				`SLP_OFS_CONVS: convs_r <= i_wdata;
				`SLP_OFS_CSN: begin
					cs_r <= i_wdata[`SLP_CS_HI:`SLP_CS_LO];
					res_r <= i_wdata[4:0];
				end
				`SLP_OFS_SUBCLASS_NP: begin
					subclass_r <= i_wdata[`SLP_SUBCLASS_HI:`SLP_SUBCLASS_LO];
					np_r <= i_wdata[4:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Descriptors are sampled from the mode logic, never from the bus
	always @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			samples_r <= 5'h00;
			dens_r <= 1'h0;
			ctrl_words_r <= 5'h00;
		end else if (i_clk_en) begin
			samples_r <= i_samples_field;
			dens_r <= i_high_density_flag;
			ctrl_words_r <= i_ctrl_words_per_frame;
		end
	end

	slp_checksum u_chk0 (
		.i_base(`SLP_CHK0_BASE),
		.i_lanes(lanes_r),
		.i_scr(scr_r),
		.i_octets(octets_r),
		.i_frames(frames_r),
		.i_convs(convs_r),
		.i_cs(cs_r),
		.i_res(res_r),
		.i_subclass(subclass_r),
		.i_np(np_r),
		.i_samples(samples_r),
		.i_high_density(dens_r),
		.i_ctrl_words(ctrl_words_r),
		.o_sum(chk0_nxt)
	);

	// Refreshed every enabled cycle, so it trails any write by one cycle
	always @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			chk0_r <= `SLP_RST_CHK0;
		end else if (i_clk_en) begin
			chk0_r <= chk0_nxt;
		end
	end

	// Control bits attached per sample, bit 2 first
	always @* begin
		case (cs_r)
			2'h0: mask_nxt = 3'h0;
			2'h1: mask_nxt = 3'h4;
			2'h2: mask_nxt = 3'h6;
			`SLP_CS_ALL: mask_nxt = 3'h7;
			default: mask_nxt = 3'h0;
		endcase
	end

	assign fk_product = ({6'h00, octets_r} + 14'h0001) * ({9'h000, frames_r} + 14'h0001);

	always @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			mask_r <= 3'h0;
			octets_out_r <= 9'h001;
			frames_out_r <= 6'h20;
			samples_out_r <= 6'h01;
			legal_r <= 1'h1;
		end else if (i_clk_en) begin
			mask_r <= mask_nxt;
			octets_out_r <= {1'h0, octets_r} + 9'h001;
			frames_out_r <= {1'h0, frames_r} + 6'h01;
			samples_out_r <= {1'h0, samples_r} + 6'h01;
			legal_r <= (fk_product[1:0] == 2'h0);
		end
	end

	// Read path: data one cycle after the strobe, zero otherwise
	always @* begin
		rdata_nxt = 8'h00;
		if (i_rd) begin
			case (i_addr)
				`SLP_OFS_LANES: rdata_nxt = {scr_r, 2'h0, lanes_r};
				`SLP_OFS_OCTETS: rdata_nxt = octets_r;
				`SLP_OFS_FRAMES: rdata_nxt = {3'h0, frames_r};
				`SLP_OFS_CONVS: rdata_nxt = convs_r;
				`SLP_OFS_CSN: rdata_nxt = {cs_r, 1'h0, res_r};
				`SLP_OFS_SUBCLASS_NP: rdata_nxt = {subclass_r, np_r};
				`SLP_OFS_SAMPLES: rdata_nxt = {`SLP_SAMPLES_RSVD, samples_r};
				`SLP_OFS_DENSITY_CTRL: rdata_nxt = {dens_r, 2'h0, ctrl_words_r};
				`SLP_OFS_CHK0: rdata_nxt = chk0_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			rdata_r <= 8'h00;
		end else if (i_clk_en) begin
			rdata_r <= rdata_nxt;
		end
	end

	assign o_rdata = rdata_r;
	assign o_ctrl_bit_mask = mask_r;
	assign o_resolution = res_r;
	assign o_lanes_field = lanes_r;
	assign o_scrambler_en = scr_r;
	assign o_octets_per_frame = octets_out_r;
	assign o_frames_per_multiframe = frames_out_r;
	assign o_converters = convs_r;
	assign o_subclass = subclass_r;
	assign o_bits_per_sample = np_r;
	assign o_samples_per_frame = samples_out_r;
	assign o_high_density = dens_r;
	assign o_ctrl_words = ctrl_words_r;
	assign o_frame_size_legal = legal_r;
	assign o_lane_zero_checksum = chk0_r;
endmodule // slp_regs

//--- slp_regs_sva.sv
/* Assertion checker for the link parameter register bank.
   Assumes a bind onto slp_regs and one free-running reference clock. */
`include "slp_defines.vh"
module slp_regs_chk (
	// Clock and register port
	input logic I_REF_CLK,
	input logic I_SYS_RST,
	input logic i_clk_en,
	input logic [`SLP_ADDR_W-1:0] i_addr,
	input logic [7:0] i_wdata,
	input logic i_wr,
	input logic i_rd,
	input logic [7:0] o_rdata,
	// Descriptors
	input logic [4:0] i_samples_field,
	input logic i_high_density_flag,
	input logic [4:0] i_ctrl_words_per_frame,
	// Link outputs
	input logic [2:0] o_ctrl_bit_mask,
	input logic [8:0] o_octets_per_frame,
	input logic [7:0] o_converters,
	input logic [5:0] o_samples_per_frame,
	input logic o_high_density,
	input logic [4:0] o_ctrl_words,
	input logic [7:0] o_lane_zero_checksum
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (I_SYS_RST);
	wire wr_en = i_clk_en && i_wr;
	a_mask_all_three: assert property (
		(wr_en && i_addr == `SLP_OFS_CSN && i_wdata[7:6] == 2'h3) ##1 i_clk_en |=> o_ctrl_bit_mask == 3'h7)
		else $error("control bit mask not all set");
	a_samples_plus_one: assert property (
		i_clk_en [*3] |-> o_samples_per_frame == {1'b0, $past(i_samples_field, 2)} + 6'h01)
		else $error("samples per frame wrong");
	a_density_follows: assert property (
		i_clk_en |=> o_high_density == $past(i_high_density_flag))
		else $error("density flag wrong");
	a_ctrl_words_direct: assert property (
		i_clk_en && $changed(i_ctrl_words_per_frame) |=> o_ctrl_words == $past(i_ctrl_words_per_frame))
		else $error("control words wrong");
	// A descriptor moving in the same cycle could cancel the converter change in the sum
	a_chk_on_write: assert property (
		(wr_en && i_addr == `SLP_OFS_CONVS && i_wdata != o_converters && $stable(i_samples_field)
		&& $stable(i_high_density_flag) && $stable(i_ctrl_words_per_frame)) ##1 i_clk_en [*2]
		|-> o_lane_zero_checksum != $past(o_lane_zero_checksum))
		else $error("checksum ignored a write");
	a_chk_readback: assert property (
		i_clk_en && i_rd && i_addr == `SLP_OFS_CHK0 |=> o_rdata == $past(o_lane_zero_checksum))
		else $error("checksum read wrong");
	a_octets_plus_one: assert property (
		(wr_en && i_addr == `SLP_OFS_OCTETS) ##1 i_clk_en ##1 i_clk_en
		|-> o_octets_per_frame == {1'b0, $past(i_wdata, 2)} + 9'h001)
		else $error("octets per frame wrong");
	a_rdata_quiet: assert property (
		i_clk_en && !i_rd |=> o_rdata == 8'h00)
		else $error("read data outside read");
	c_cs_all: cover property (wr_en && i_addr == `SLP_OFS_CSN && i_wdata[7:6] == 2'h3);
	c_chk_read: cover property (i_clk_en && i_rd && i_addr == `SLP_OFS_CHK0);
	c_frozen_wr: cover property (!i_clk_en && i_wr);
endmodule // slp_regs_chk

bind slp_regs slp_regs_chk u_slp_regs_chk (
	.I_REF_CLK(I_REF_CLK),
	.I_SYS_RST(I_SYS_RST),
	.i_clk_en(i_clk_en),
	.i_addr(i_addr),
	.i_wdata(i_wdata),
	.i_wr(i_wr),
	.i_rd(i_rd),
	.o_rdata(o_rdata),
	.i_samples_field(i_samples_field),
	.i_high_density_flag(i_high_density_flag),
	.i_ctrl_words_per_frame(i_ctrl_words_per_frame),
	.o_ctrl_bit_mask(o_ctrl_bit_mask),
	.o_octets_per_frame(o_octets_per_frame),
	.o_converters(o_converters),
	.o_samples_per_frame(o_samples_per_frame),
	.o_high_density(o_high_density),
	.o_ctrl_words(o_ctrl_words),
	.o_lane_zero_checksum(o_lane_zero_checksum)
);

//--- tb_slp_regs.sv
/* Self-checking bench for the link parameter register bank.
   Assumes read data one cycle after the read strobe. */
`include "slp_defines.vh"
module tb_slp_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic I_REF_CLK = 1'b0;
	logic I_SYS_RST = 1'b1;
	logic i_clk_en = 1'b1;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_high_density_flag = 1'b0;
	logic [11:0] i_addr = 12'h000;
	logic [7:0] i_wdata = 8'h00;
	logic [4:0] i_samples_field = 5'h00;
	logic [4:0] i_ctrl_words_per_frame = 5'h00;
	wire [7:0] o_rdata, o_converters, o_lane_zero_checksum;
	wire [2:0] o_ctrl_bit_mask, o_subclass;
	wire [4:0] o_resolution, o_lanes_field, o_bits_per_sample, o_ctrl_words;
	wire [8:0] o_octets_per_frame;
	wire [5:0] o_frames_per_multiframe, o_samples_per_frame;
	wire o_scrambler_en, o_high_density, o_frame_size_legal;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;
	logic [11:0] ra [9] = '{12'h58b, 12'h58c, 12'h58d, 12'h58e, 12'h58f, 12'h590, 12'h591, 12'h592, 12'h5a0};
	// Reserved bits read zero except the fixed pattern above the samples field
	logic [7:0] rv [9] = '{8'h07, 8'h00, 8'h1f, 8'h01, 8'h0f, 8'h2f, 8'h20, 8'h00, 8'hc3};
	slp_regs u_slp_regs (
		.I_REF_CLK(I_REF_CLK),
		.I_SYS_RST(I_SYS_RST),
		.i_clk_en(i_clk_en),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rdata(o_rdata),
		.i_samples_field(i_samples_field),
		.i_high_density_flag(i_high_density_flag),
		.i_ctrl_words_per_frame(i_ctrl_words_per_frame),
		.o_ctrl_bit_mask(o_ctrl_bit_mask),
		.o_resolution(o_resolution),
		.o_lanes_field(o_lanes_field),
		.o_scrambler_en(o_scrambler_en),
		.o_octets_per_frame(o_octets_per_frame),
		.o_frames_per_multiframe(o_frames_per_multiframe),
		.o_converters(o_converters),
		.o_subclass(o_subclass),
		.o_bits_per_sample(o_bits_per_sample),
		.o_samples_per_frame(o_samples_per_frame),
		.o_high_density(o_high_density),
		.o_ctrl_words(o_ctrl_words),
		.o_frame_size_legal(o_frame_size_legal),
		.o_lane_zero_checksum(o_lane_zero_checksum)
	);
	initial forever #20 I_REF_CLK = ~I_REF_CLK;
	task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		@(posedge I_REF_CLK);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge I_REF_CLK);
		i_wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [11:0] a, input logic [7:0] exp);
		@(posedge I_REF_CLK);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge I_REF_CLK);
		i_rd <= 1'b0;
		#1 check({1'b0, o_rdata}, {1'b0, exp}, $sformatf("reg %h", a));
	endtask
	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge I_REF_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_fail++;
			test_done();
		end
	end
	initial begin
		repeat (4) @(posedge I_REF_CLK);
		I_SYS_RST <= 1'b0;
		for (int i = 0; i < 9; i++) rd_reg(ra[i], rv[i]);
		check(o_octets_per_frame, 9'h001, "octets");
		check(o_frames_per_multiframe, 9'h020, "frames");
		check(o_frame_size_legal, 9'h001, "frame size legal");
		check(o_lanes_field, 9'h007, "lanes");
		check(o_scrambler_en, 9'h000, "scrambler");
		check(o_subclass, 9'h001, "subclass");
		check(o_bits_per_sample, 9'h00f, "bits per sample");
		check(o_resolution, 9'h00f, "resolution");
		for (int c = 0; c < 4; c++) begin
			wr_reg(`SLP_OFS_CSN, {c[1:0], 6'h00});
			repeat (2) @(posedge I_REF_CLK);
			#1 check(o_ctrl_bit_mask, 3'(3'h7 << (3 - c)), "control bit mask");
		end
		rd_reg(`SLP_OFS_CSN, 8'hc0);
		check(o_resolution, 9'h000, "resolution");
		// Frame size kept legal: 16 octets times 4 frames
		wr_reg(`SLP_OFS_OCTETS, 8'h0f);
		wr_reg(`SLP_OFS_FRAMES, 8'h03);
		repeat (2) @(posedge I_REF_CLK);
		#1 check(o_octets_per_frame, 9'h010, "octets");
		check(o_frames_per_multiframe, 9'h004, "frames");
		check(o_frame_size_legal, 9'h001, "frame size legal");
		@(posedge I_REF_CLK);
		i_samples_field <= 5'h03;
		i_high_density_flag <= 1'b1;
		i_ctrl_words_per_frame <= 5'h02;
		repeat (3) @(posedge I_REF_CLK);
		#1 check(o_samples_per_frame, 9'h004, "samples");
		check(o_high_density, 9'h001, "density");
		check(o_ctrl_words, 9'h002, "control words");
		wr_reg(`SLP_OFS_SAMPLES, 8'hff);
		wr_reg(`SLP_OFS_DENSITY_CTRL, 8'h7f);
		wr_reg(`SLP_OFS_CHK0, 8'h00);
		wr_reg(12'h5a1, 8'h55);
		rd_reg(`SLP_OFS_SAMPLES, 8'h23);
		rd_reg(`SLP_OFS_DENSITY_CTRL, 8'h82);
		rd_reg(12'h5a1, 8'h00);
		// Converter count large enough that the sum wraps past 255
		wr_reg(`SLP_OFS_CONVS, 8'h90);
		repeat (2) @(posedge I_REF_CLK);
		#1 check(o_lane_zero_checksum, 8'(8'h7d + 8'h07 + 8'h0f + 8'h03 + 8'h90 + 8'h03 + 8'h01 + 8'h0f + 8'h03
			+ 8'h01 + 8'h02), "checksum");
		rd_reg(`SLP_OFS_CHK0, 8'h3f);
		check(o_converters, 9'h090, "converters");
		@(posedge I_REF_CLK);
		i_clk_en <= 1'b0;
		wr_reg(`SLP_OFS_LANES, 8'h01);
		@(posedge I_REF_CLK);
		i_clk_en <= 1'b1;
		rd_reg(`SLP_OFS_LANES, 8'h07);
		@(posedge I_REF_CLK);
		i_samples_field <= 5'h00;
		i_high_density_flag <= 1'b0;
		i_ctrl_words_per_frame <= 5'h00;
		I_SYS_RST <= 1'b1;
		repeat (2) @(posedge I_REF_CLK);
		#1 check(o_lane_zero_checksum, 9'h0c3, "checksum");
		check(o_rdata, 9'h000, "read data in reset");
		// Release again: parameters back at reset, checksum rebuilt from them
		@(posedge I_REF_CLK);
		I_SYS_RST <= 1'b0;
		rd_reg(`SLP_OFS_CONVS, 8'h01);
		rd_reg(`SLP_OFS_CHK0, 8'hc3);
		test_done();
	end
endmodule // tb_slp_regs
